// *** verilog/epec_counter_bank.sv ***
// epec_counter_bank: apb register bank of e1 performance-monitor error counters
//
// What this block does
// RL1 - eight-bit tally of transmit frame slips
// RL2 - one repeated or dropped frame counts once
// RL3 - reading slip tally returns it, then zeroes
// RL4 - sixteen-bit tally of excessive zero violations
// RL5 - high register bits 15..8, low 7..0
// RL6 - reading zero violation bytes restarts its tally
// RL7 - software reads high first; low matches it
// RL8 - only high-then-low read pair clears tally
// RL9 - eight-bit clear-on-read link 2 check errors
// RL10 - eight-bit clear-on-read link 3 check errors
// RL11 - event during clearing read counts as first
// RL12 - tallies hold at all ones, never wrap
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
module epec_counter_bank (
    input  wire logic         pclk,                       // bus clock, 200 MHz
    input  wire logic         presetn,                    // async reset, low active
    input  wire logic         psel,                       // apb select
    input  wire logic         penable,                    // apb access phase
    input  wire logic         pwrite,                     // apb direction, high write
    input  wire logic [15:0]  paddr,                      // apb byte address
    input  wire logic [31:0]  pwdata,                     // apb write data
    input  wire logic [3:0]   pstrb,                      // apb byte strobes
    output logic              pready,                     // apb transfer done
    output logic [31:0]       prdata,                     // apb read data
    output logic              pslverr,                    // apb error, unmapped address
    input  wire logic         slip_event,                 // slip buffer repeated or dropped frame
    input  wire logic         zero_violation_event,       // receive framer zero violation
    input  wire logic         link2_check_error_event,    // link 2 controller check error
    input  wire logic         link3_check_error_event,    // link 3 controller check error
    output logic              irq                         // level interrupt, high active
);

    // ==========================================================
    // bank state
    // ==========================================================
    typedef struct packed {
        logic        pready;                              // answer flag
        logic        pslverr;                             // error flag
        logic [31:0] prdata;                              // read data
        logic [3:0]  status;                              // sticky event bits
        logic [3:0]  mask;                                // interrupt enables
        logic        irq;                                 // interrupt level
    } epec_bank_state_t;

    epec_bank_state_t state_ff;                           // registered state
    epec_bank_state_t nxt_state;                          // next state

    // ==========================================================
    // decode helpers
    // ==========================================================
    // word hit: compare address word against a register index
    function automatic logic epec_hit(input logic [15:0] addr,
                                      input logic [15:0] idx);
        return addr[epec_pkg::ADDR_W-1:epec_pkg::IDX_LSB]
               == idx[epec_pkg::ADDR_W-epec_pkg::IDX_LSB-1:0];
    endfunction : epec_hit

    // place a byte in the low lane of a data word
    function automatic logic [31:0] epec_word(input logic [7:0] value);
        return {24'h00_0000, value};
    endfunction : epec_word

    // ==========================================================
    // apb request decode
    // ==========================================================
    logic        take;                                    // access phase, answer not yet given
    logic        take_rd;                                 // read taken this edge
    logic        take_wr;                                 // write taken this edge
    logic        hit_slip;                                // slip tally selected
    logic        hit_high;                                // zero violation high byte selected
    logic        hit_low;                                 // zero violation low byte selected
    logic        hit_link2;                               // link 2 tally selected
    logic        hit_link3;                               // link 3 tally selected
    logic        hit_status;                              // event status selected
    logic        hit_mask;                                // event mask selected
    logic        hit_any;                                 // some register selected

    // a request is taken once, in the first access cycle
    assign take    = psel && penable && !state_ff.pready;
    assign take_rd = take && !pwrite;
    assign take_wr = take && pwrite;

    assign hit_slip   = epec_hit(paddr, epec_pkg::IDX_TRANSMIT_SLIP_COUNT);
    assign hit_high   = epec_hit(paddr, epec_pkg::IDX_ZERO_VIOLATION_COUNT_HIGH);
    assign hit_low    = epec_hit(paddr, epec_pkg::IDX_ZERO_VIOLATION_COUNT_LOW);
    assign hit_link2  = epec_hit(paddr, epec_pkg::IDX_LINK2_CHECK_ERROR_COUNT);
    assign hit_link3  = epec_hit(paddr, epec_pkg::IDX_LINK3_CHECK_ERROR_COUNT);
    assign hit_status = epec_hit(paddr, epec_pkg::IDX_EVENT_STATUS);
    assign hit_mask   = epec_hit(paddr, epec_pkg::IDX_EVENT_MASK);
    assign hit_any    = hit_slip || hit_high || hit_low || hit_link2
                        || hit_link3 || hit_status || hit_mask;

    // ==========================================================
    // counters
    // ==========================================================
    logic [7:0]  tx_frame_slip_tally;                     // slip tally value
    logic [7:0]  link2_check_error_tally;                 // link 2 tally value
    logic [7:0]  link3_check_error_tally;                 // link 3 tally value
    logic [15:0] zero_violation_tally;                    // live zero violation tally
    logic [15:0] zero_violation_snap;                     // tally frozen at high read
    logic        zero_violation_armed;                    // high byte read, low due

    // slip tally: each slip pulse is one whole frame repeated or dropped
    epec_sat_counter #(
        .W        (epec_pkg::BYTE_W)
    ) u_slip (
        .pclk     (pclk),
        .presetn  (presetn),
        .event_in (slip_event),                           // [RL1] [RL2]
        .clear_in (take_rd && hit_slip),                  // [RL3]
        .count    (tx_frame_slip_tally)
    );

    // zero violation tally, read as an ordered byte pair
    epec_split_counter #(
        .W        (epec_pkg::WIDE_W)
    ) u_zero (
        .pclk     (pclk),
        .presetn  (presetn),
        .event_in (zero_violation_event),                 // [RL4]
        .upper_rd (take_rd && hit_high),                  // [RL8]
        .lower_rd (take_rd && hit_low),                   // [RL6] [RL8]
        .count    (zero_violation_tally),
        .snap     (zero_violation_snap),
        .armed    (zero_violation_armed)
    );

    // link 2 check error tally
    epec_sat_counter #(
        .W        (epec_pkg::BYTE_W)
    ) u_link2 (
        .pclk     (pclk),
        .presetn  (presetn),
        .event_in (link2_check_error_event),              // [RL9]
        .clear_in (take_rd && hit_link2),                 // [RL9]
        .count    (link2_check_error_tally)
    );

    // link 3 check error tally
    epec_sat_counter #(
        .W        (epec_pkg::BYTE_W)
    ) u_link3 (
        .pclk     (pclk),
        .presetn  (presetn),
        .event_in (link3_check_error_event),              // [RL10]
        .clear_in (take_rd && hit_link3),                 // [RL10]
        .count    (link3_check_error_tally)
    );

    // ==========================================================
    // read data select
    // ==========================================================
    logic [7:0]  low_byte;                                // lower byte shown to software
    logic [31:0] rd_word;                                 // word for the current address
    logic [3:0]  evt_now;                                 // events this cycle

    // lower byte matches the high byte already read while a pair is open
    assign low_byte = zero_violation_armed ? zero_violation_snap[7:0]      // [RL7]
                                           : zero_violation_tally[7:0];

    assign evt_now = {link3_check_error_event, link2_check_error_event,
                      zero_violation_event, slip_event};

    // word returned for each mapped address
    always_comb
    begin
        rd_word = 32'h0000_0000;
        if (hit_slip)
            rd_word = epec_word(tx_frame_slip_tally);
        else if (hit_high)
            rd_word = epec_word(zero_violation_tally[15:8]);        // [RL5]
        else if (hit_low)
            rd_word = epec_word(low_byte);                          // [RL5]
        else if (hit_link2)
            rd_word = epec_word(link2_check_error_tally);
        else if (hit_link3)
            rd_word = epec_word(link3_check_error_tally);
        else if (hit_status)
            rd_word = {28'h000_0000, state_ff.status};
        else if (hit_mask)
            rd_word = {28'h000_0000, state_ff.mask};
    end

    // ==========================================================
    // next state: bus answer, status, mask, interrupt
    // ==========================================================
    always_comb
    begin
        nxt_state         = state_ff;
        nxt_state.pready  = 1'b0;
        nxt_state.pslverr = 1'b0;
        // answer one cycle after the request is taken
        if (take)
        begin
            nxt_state.pready  = 1'b1;
            nxt_state.pslverr = !hit_any;
            nxt_state.prdata  = (take_rd && hit_any) ? rd_word : 32'h0000_0000;
        end
        // status read clears, but a new event in the same cycle wins
        if (take_rd && hit_status)
            nxt_state.status = evt_now;
        else
            nxt_state.status = state_ff.status | evt_now;
        // mask is the only writable register, low byte lane
        if (take_wr && hit_mask && pstrb[0])
            nxt_state.mask = pwdata[epec_pkg::EVT_W-1:0];
        // interrupt follows the registered status and mask
        nxt_state.irq = |(nxt_state.status & nxt_state.mask);
    end

    // ==========================================================
    // register
    // ==========================================================
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff         <= '0;
            state_ff.status  <= epec_pkg::EVT_RESET;
            state_ff.mask    <= epec_pkg::EVT_RESET;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // ==========================================================
    // outputs, all from flops
    // ==========================================================
    assign pready  = state_ff.pready;
    assign pslverr = state_ff.pslverr;
    assign prdata  = state_ff.prdata;
    assign irq     = state_ff.irq;

endmodule : epec_counter_bank

// *** common/epec_pkg.sv ***
// epec_pkg: register map, field layout and shared arithmetic of the error counter bank
package epec_pkg;

    // ==========================================================
    // register indices (byte address is four times the index)
    // ==========================================================
    localparam logic [15:0] IDX_TRANSMIT_SLIP_COUNT       = 16'h090f; // slip tally
    localparam logic [15:0] IDX_ZERO_VIOLATION_COUNT_HIGH = 16'h0910; // tally bits 15..8
    localparam logic [15:0] IDX_ZERO_VIOLATION_COUNT_LOW  = 16'h0911; // tally bits 7..0
    localparam logic [15:0] IDX_LINK2_CHECK_ERROR_COUNT   = 16'h091c; // link 2 check errors
    localparam logic [15:0] IDX_LINK3_CHECK_ERROR_COUNT   = 16'h092c; // link 3 check errors
    localparam logic [15:0] IDX_EVENT_STATUS              = 16'h0930; // sticky events
    localparam logic [15:0] IDX_EVENT_MASK                = 16'h0931; // interrupt mask

    // ==========================================================
    // widths and reset values
    // ==========================================================
    localparam int          ADDR_W      = 16;             // apb address width
    localparam int          DATA_W      = 32;             // apb data width
    localparam int          BYTE_W      = 8;              // register payload width
    localparam int          WIDE_W      = 16;             // split counter width
    localparam int          IDX_LSB     = 2;              // word index starts here
    localparam int          EVT_W       = 4;              // number of event sources
    localparam logic [7:0]  COUNT_RESET = 8'h00;          // counter reset value
    localparam logic [3:0]  EVT_RESET   = 4'h0;           // status and mask reset value

    // ==========================================================
    // event bit positions in status and mask
    // ==========================================================
    localparam int EVT_SLIP   = 0;                        // transmit slip seen
    localparam int EVT_ZERO   = 1;                        // zero violation seen
    localparam int EVT_LINK2  = 2;                        // link 2 check error seen
    localparam int EVT_LINK3  = 3;                        // link 3 check error seen

    // ==========================================================
    // saturating increment shared by all counters
    // ==========================================================
    function automatic logic [15:0] epec_sat_inc(input logic [15:0] value,
                                                 input logic [15:0] top);
        if (value == top)
            return value;                                 // hold at all ones
        return value + 16'h0001;
    endfunction : epec_sat_inc

endpackage : epec_pkg

// *** verilog/epec_sat_counter.sv ***
// epec_sat_counter: saturating counter cleared by a single read
`timescale 1ns/1ps
module epec_sat_counter #(
    parameter int W = 8                                   // counter width
) (
    input  wire logic         pclk,                       // bus clock
    input  wire logic         presetn,                    // async reset, low active
    input  wire logic         event_in,                   // one-cycle event pulse
    input  wire logic         clear_in,                   // clearing read this cycle
    output logic [W-1:0]      count                       // current tally
);

    // ==========================================================
    // state
    // ==========================================================
    typedef struct packed {
        logic [W-1:0] count;                              // running tally
    } epec_cnt_state_t;

    epec_cnt_state_t state_ff;                            // registered state
    epec_cnt_state_t nxt_state;                           // next state

    localparam logic [15:0] TOP = 16'((1 << W) - 1);      // all ones at width W

    // next value: clear restarts, event still counted
    always_comb
    begin
        nxt_state = state_ff;
        if (clear_in)
            nxt_state.count = event_in ? W'(1) : '0;     // [RL3] [RL11]
        else if (event_in)
            nxt_state.count = W'(epec_pkg::epec_sat_inc(16'(state_ff.count), TOP)); // [RL12]
    end

    // register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_ff <= '0;
        else
            state_ff <= nxt_state;
    end

    assign count = state_ff.count;

endmodule : epec_sat_counter

// *** verilog/epec_split_counter.sv ***
// epec_split_counter: wide counter read as upper then lower byte
`timescale 1ns/1ps
module epec_split_counter #(
    parameter int W = 16                                  // counter width
) (
    input  wire logic         pclk,                       // bus clock
    input  wire logic         presetn,                    // async reset, low active
    input  wire logic         event_in,                   // one-cycle event pulse
    input  wire logic         upper_rd,                   // upper byte read taken
    input  wire logic         lower_rd,                   // lower byte read taken
    output logic [W-1:0]      count,                      // live tally
    output logic [W-1:0]      snap,                       // value frozen at upper read
    output logic              armed                       // upper read seen, lower due
);

    // ==========================================================
    // state
    // ==========================================================
    typedef struct packed {
        logic [W-1:0] count;                              // live tally
        logic [W-1:0] snap;                               // snapshot for the lower read
        logic         armed;                              // pair in progress
    } epec_split_state_t;

    epec_split_state_t state_ff;                          // registered state
    epec_split_state_t nxt_state;                         // next state

    localparam logic [15:0] TOP = 16'((1 << W) - 1);      // all ones at width W

    // snapshot on upper read, subtract it on the matching lower read
    always_comb
    begin
        logic [W-1:0] base;
        base      = state_ff.count;
        nxt_state = state_ff;
        if (lower_rd && state_ff.armed)
        begin
            base            = state_ff.count - state_ff.snap; // [RL6] [RL8] keeps later events
            nxt_state.armed = 1'b0;
        end
        if (upper_rd)
        begin
            nxt_state.snap  = state_ff.count;             // [RL7] freeze lower byte
            nxt_state.armed = 1'b1;
        end
        if (event_in)
            nxt_state.count = W'(epec_pkg::epec_sat_inc(16'(base), TOP)); // [RL4] [RL11] [RL12]
        else
            nxt_state.count = base;
    end

    // register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_ff <= '0;
        else
            state_ff <= nxt_state;
    end

    assign count = state_ff.count;
    assign snap  = state_ff.snap;
    assign armed = state_ff.armed;

endmodule : epec_split_counter

// *** verif/epec_counter_bank_props.sv ***
// epec_counter_bank_props: bus handshake, read data and interrupt checks of the counter bank
`timescale 1ns/1ps
module epec_counter_bank_props (
    input  wire logic         pclk,                       // bus clock
    input  wire logic         presetn,                    // async reset, low active
    input  wire logic         psel,                       // apb select
    input  wire logic         penable,                    // apb access phase
    input  wire logic         pwrite,                     // apb direction
    input  wire logic [15:0]  paddr,                      // apb byte address
    input  wire logic [31:0]  pwdata,                     // apb write data
    input  wire logic [3:0]   pstrb,                      // apb byte strobes
    input  wire logic         pready,                     // apb transfer done
    input  wire logic [31:0]  prdata,                     // apb read data
    input  wire logic         pslverr,                    // apb error
    input  wire logic         slip_event,                 // slip pulse
    input  wire logic         zero_violation_event,       // zero violation pulse
    input  wire logic         link2_check_error_event,    // link 2 pulse
    input  wire logic         link3_check_error_event,    // link 3 pulse
    input  wire logic         irq                         // level interrupt
);
    // ==========================================================
    // shared terms
    // ==========================================================
    logic take;                                           // first access cycle
    logic any_ev;                                         // some event pulse this cycle
    assign take   = psel && penable && !pready;
    assign any_ev = slip_event || zero_violation_event || link2_check_error_event
                    || link3_check_error_event;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ==========================================================
    // handshake and read data
    // ==========================================================
    a_ready_after_take: assert property (take |=> pready)
        else $error("no answer one cycle after access");
    a_ready_single: assert property (pready |=> !pready)
        else $error("ready held two cycles");
    a_ready_cause: assert property (!take |=> !pready)
        else $error("ready without access");
    a_error_zero: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
        else $error("error answer carries data");
    a_byte_payload: assert property (pready |-> prdata[31:8] == 24'h00_0000)
        else $error("register wider than a byte");
    a_data_holds: assert property (!pready |-> $stable(prdata))
        else $error("read data moved without answer");
    a_write_no_data: assert property (pready && pwrite |-> prdata == 32'h0000_0000)
        else $error("write answer carries data");

    // ==========================================================
    // interrupt causes
    // ==========================================================
    a_irq_rise_cause: assert property ($rose(irq) |-> $past(any_ev) || $past(any_ev, 2)
        || $past(take && pwrite) || $past(take && pwrite, 2))
        else $error("interrupt rose without event or mask write");
    a_irq_fall_cause: assert property ($fell(irq) |-> $past(take) || $past(take, 2))
        else $error("interrupt fell without bus access");
endmodule : epec_counter_bank_props

// *** verif/test_e1_performance_monitor_error_counters.sv ***
// test_e1_performance_monitor_error_counters: self-checking bench of the counter bank
`timescale 1ns/1ps
module test_e1_performance_monitor_error_counters;
    // ==========================================================
    // signals and counters
    // ==========================================================
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [15:0] paddr;                                   // byte address
    logic [31:0] pwdata, prdata, rd;                      // bus data and read result
    logic [3:0]  pstrb, ev;                               // strobes, event pulses
    logic        er;                                      // error from last transfer
    int          err_count, checks_done;                  // report counters
    typedef struct { logic [3:0] ev; int n; logic [15:0] a; logic [31:0] x; logic e; } epec_row_t;
    epec_row_t   rows[11];                                // ordinary cases

    epec_counter_bank i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .slip_event(ev[0]), .zero_violation_event(ev[1]),
        .link2_check_error_event(ev[2]), .link3_check_error_event(ev[3]), .irq(irq));

    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;                        // 200 MHz
    end

    // ==========================================================
    // tasks
    // ==========================================================
    task automatic conclude();
        $display("mismatches %0d, checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    // one apb transfer, released only after the edge that samples pready
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] wd);
        int k;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        if (k >= 20)
        begin
            err_count++;
            $display("FAIL %0t bus answer missing", $time);
            conclude();
        end
    endtask : apb

    // n event cycles on the lines set in m
    task automatic pulse(input logic [3:0] m, input int n);
        repeat (n)
        begin
            @(posedge pclk);
            ev <= m;
        end
        @(posedge pclk);
        ev <= 4'h0;
    endtask : pulse

    // ==========================================================
    // main sequence
    // ==========================================================
    initial
    begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 16'h0000;
        pwdata = 32'h0000_0000; pstrb = 4'hf; ev = 4'h0; err_count = 0; checks_done = 0;
        rows = '{'{4'h1, 3, 16'h243c, 32'h3, 0},
                 '{4'h0, 0, 16'h243c, 32'h0, 0},
                 '{4'h4, 5, 16'h2470, 32'h5, 0},
                 '{4'h8, 7, 16'h24b0, 32'h7, 0},
                 '{4'h2, 300, 16'h2440, 32'h1, 0},
                 '{4'h0, 0, 16'h2444, 32'h2c, 0},
                 '{4'h0, 0, 16'h2440, 32'h0, 0},
                 '{4'h0, 0, 16'h2500, 32'h0, 1},
                 '{4'h0, 0, 16'h24c0, 32'hf, 0},
                 '{4'h0, 0, 16'h24c0, 32'h0, 0},
                 '{4'h0, 0, 16'h24c4, 32'h0, 0}};
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i])
        begin
            if (rows[i].n > 0) pulse(rows[i].ev, rows[i].n);
            apb(1'b0, rows[i].a, 32'h0000_0000);
            check(rd, rows[i].x, "row data");
            check({31'h0, er}, {31'h0, rows[i].e}, "row error");
        end
        // event on the clearing edge starts the new tally
        ev <= 4'h1;
        apb(1'b0, 16'h243c, 32'h0000_0000);
        ev <= 4'h0;
        check(rd, 32'h2, "slip before clear");
        apb(1'b0, 16'h243c, 32'h0000_0000);
        check(rd, 32'h2, "slip after clear");
        // events between high and low read survive the clear
        pulse(4'h2, 2);
        apb(1'b0, 16'h2440, 32'h0000_0000);
        pulse(4'h2, 3);
        apb(1'b0, 16'h2444, 32'h0000_0000);
        check(rd, 32'h2, "low after high");
        apb(1'b0, 16'h2444, 32'h0000_0000);
        check(rd, 32'h3, "lone low read");
        apb(1'b0, 16'h2444, 32'h0000_0000);
        check(rd, 32'h3, "lone low clears nothing");
        // saturation, ignored counter write
        pulse(4'h4, 260);
        apb(1'b1, 16'h243c, 32'h0000_0055);
        apb(1'b0, 16'h2470, 32'h0000_0000);
        check(rd, 32'hff, "link 2 saturation");
        apb(1'b0, 16'h243c, 32'h0000_0000);
        check(rd, 32'h0, "slip write ignored");
        // interrupt raised, masked, cleared
        apb(1'b0, 16'h24c0, 32'h0000_0000);
        apb(1'b1, 16'h24c4, 32'h0000_0001);
        pulse(4'h8, 1);
        @(negedge pclk);
        check({31'h0, irq}, 32'h0, "masked event");
        pulse(4'h1, 1);
        @(negedge pclk);
        check({31'h0, irq}, 32'h1, "unmasked event");
        apb(1'b0, 16'h24c0, 32'h0000_0000);
        check(rd, 32'h9, "status bits");
        @(negedge pclk);
        check({31'h0, irq}, 32'h0, "status read clears");
        // reset in mid-run zeroes the tallies
        pulse(4'hf, 2);
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 16'h243c, 32'h0000_0000);
        check(rd, 32'h0, "slip after reset");
        apb(1'b0, 16'h2440, 32'h0000_0000);
        check(rd, 32'h0, "high after reset");
        apb(1'b0, 16'h24c4, 32'h0000_0000);
        check(rd, 32'h0, "mask after reset");
        conclude();
    end
endmodule : test_e1_performance_monitor_error_counters

bind epec_counter_bank epec_counter_bank_props i_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .slip_event(slip_event), .zero_violation_event(zero_violation_event),
    .link2_check_error_event(link2_check_error_event),
    .link3_check_error_event(link3_check_error_event), .irq(irq));
